// ==== design/vc0_res_pkg.sv ====
// Types shared by the channel 0 resource register block
package vc0_res_pkg;
    typedef logic [31:0] word_t;
    typedef logic [2:0]  scheme_t;
    typedef enum logic [1:0] {
        LD_IDLE = 2'b01,
        LD_BUSY = 2'b10
    } load_state_t;
endpackage : vc0_res_pkg

// ==== design/vc0_res_regs.svh ====
// Register offsets, field positions and reset values for the channel 0 resource registers
`ifndef VC0_RES_REGS_SVH
`define VC0_RES_REGS_SVH

`define CAP_OFFSET        12'h150
`define CTRL_OFFSET       12'h154
`define STAT_OFFSET       12'h158

`define CAP_ARB_RST       8'h09
`define CAP_SLOTS_RST     7'h7F
`define CAP_TBL_OFS_RST   8'h04
`define CTRL_TCMAP_RST    8'hFF
`define CTRL_ENABLE_RST   1'b1
`define CHANNEL_ID        3'h0

`define CTRL_LOAD_BIT     16
`define CTRL_SEL_LSB      17
`define CTRL_SEL_MSB      19
`define CTRL_ENABLE_BIT   31
`define CAP_SLOTS_LSB     16
`define CAP_SLOTS_MSB     22

`define SCHEME_DEFAULT    3'h0
`define SCHEME_WRR128     3'h3

`define TBL_ENTRY_W       4
`define LOAD_DONE_CYCLES  4'h8

`endif

// ==== design/vc0_resource_registers.sv ====
// APB register bank for the virtual channel 0 resource capability, control and status
`timescale 1ns/1ps
`include "vc0_res_regs.svh"

// Notes on behaviour
// RULE_01 - Arbitration capability resets 09h: RR, WRR128
// RULE_02 - No time-based WRR on channel zero
// RULE_03 - Capability bits 14, 15 read zero
// RULE_04 - Time slots field 7Fh, autoload may overwrite
// RULE_05 - Table offset 04h in sixteen byte units
// RULE_06 - Traffic class map writable, resets FFh
// RULE_07 - Load bit applies table, reads zero
// RULE_08 - Select accepts 000b, 011b; else default
// RULE_09 - Channel identifier fixed read-only 000b
// RULE_10 - Channel enable writable, resets to one
// RULE_11 - Table write sets table-update status
// RULE_12 - Status clears when table load completes
// RULE_13 - Negotiation pending follows negotiation, resets zero
// RULE_14 - Table entries are four bits wide
// RULE_15 - Reserved reads zero; read-only bits unwritable
module vc0_resource_registers (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire vc0_res_pkg::word_t    pwdata,
    output logic                       pready,
    output vc0_res_pkg::word_t         prdata,
    output logic                       pslverr,
    input  wire logic                  autoload_valid,
    input  wire logic [6:0]            autoload_time_slots,
    input  wire logic [7:0]            autoload_tc_map,
    input  wire logic                  table_entry_write,
    input  wire logic                  negotiation_pending_in,
    output logic [7:0]                 traffic_class_channel_map,
    output vc0_res_pkg::scheme_t       arb_scheme,
    output logic                       channel_enable,
    output logic                       table_load_pulse,
    output logic                       table_update_pending
);
    import vc0_res_pkg::*;

    // ------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------
    // Negotiation state comes from the link side, outside this domain
    logic neg_meta_r;
    logic neg_sync_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            neg_meta_r <= 1'b0;
            neg_sync_r <= 1'b0;
        end else begin
            neg_meta_r <= negotiation_pending_in;
            neg_sync_r <= neg_meta_r;
        end
    end

    // ------------------------------------------------
    // Storage
    // ------------------------------------------------
    logic [6:0]  slots_r;
    logic [7:0]  tcmap_r;
    scheme_t     sel_r;
    logic        enable_r;
    logic        tbl_status_r;
    logic        load_pulse_r;
    logic [3:0]  load_cnt_r;
    logic [3:0]  load_cnt_nxt;
    load_state_t ld_state_r;
    load_state_t ld_state_nxt;

    // ------------------------------------------------
    // Decode
    // ------------------------------------------------
    function automatic scheme_t legal_scheme(input scheme_t s);
        // Time-based WRR is not offered here, so 100b falls to default
        legal_scheme = (s == `SCHEME_WRR128) ? `SCHEME_WRR128 : `SCHEME_DEFAULT; // see RULE_02
    endfunction : legal_scheme

    wire acc      = psel && penable;
    wire hit_cap  = (paddr == `CAP_OFFSET);
    wire hit_ctrl = (paddr == `CTRL_OFFSET);
    wire hit_stat = (paddr == `STAT_OFFSET);
    wire hit_any  = hit_cap || hit_ctrl || hit_stat;
    wire wr_ctrl  = acc && pwrite && hit_ctrl;
    wire load_cmd = wr_ctrl && pwdata[`CTRL_LOAD_BIT];                 // see RULE_07
    wire scheme_t sel_wr = legal_scheme(pwdata[`CTRL_SEL_MSB:`CTRL_SEL_LSB]); // see RULE_08

    // Capability bits 15:14 and 13:8, 23 are constant zero
    wire word_t cap_word  = {`CAP_TBL_OFS_RST, 1'b0, slots_r,          // see RULE_05
                             8'h00, `CAP_ARB_RST};                     // see RULE_01 RULE_03
    wire word_t ctrl_word = {enable_r, 4'h0, `CHANNEL_ID, 4'h0, sel_r, 1'b0,
                             8'h00, tcmap_r};                          // see RULE_09
    wire word_t stat_word = {14'h0000, neg_sync_r, tbl_status_r, 16'h0000}; // see RULE_13
    wire word_t rd_word   = hit_cap  ? cap_word  :
                            hit_ctrl ? ctrl_word :
                            hit_stat ? stat_word : 32'h00000000;       // see RULE_15

    // ------------------------------------------------
    // APB response
    // ------------------------------------------------
    // Zero wait state: pready is registered high only in the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !hit_any;
            prdata  <= (psel && !penable && !pwrite) ? rd_word : 32'h00000000;
        end
    end

    // ------------------------------------------------
    // Control and capability fields
    // ------------------------------------------------
    // Write happens at the access edge; pready is high then by construction
    wire wr_go = wr_ctrl && pready;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slots_r  <= `CAP_SLOTS_RST;                                // see RULE_04
            tcmap_r  <= `CTRL_TCMAP_RST;                               // see RULE_06
            sel_r    <= `SCHEME_DEFAULT;
            enable_r <= `CTRL_ENABLE_RST;                              // see RULE_10
        end else if (wr_go) begin
            tcmap_r  <= pwdata[7:0];                                   // see RULE_06
            sel_r    <= sel_wr;                                        // see RULE_08
            enable_r <= pwdata[`CTRL_ENABLE_BIT];                      // see RULE_10
        end else if (autoload_valid) begin
            slots_r  <= autoload_time_slots;                           // see RULE_04
            tcmap_r  <= autoload_tc_map;
        end
    end

    // ------------------------------------------------
    // Table load sequencer
    // ------------------------------------------------
    // Copy of 4-bit entries takes a fixed number of cycles in the arbiter
    wire load_go = load_cmd && pready;                                 // see RULE_14
    wire load_done = (ld_state_r == LD_BUSY) && (load_cnt_r == 4'h0);

    always_comb begin
        ld_state_nxt = ld_state_r;
        load_cnt_nxt = load_cnt_r;
        case (ld_state_r)
            LD_IDLE: begin
                if (load_go) begin
                    ld_state_nxt = LD_BUSY;
                    load_cnt_nxt = `LOAD_DONE_CYCLES - 4'h1;
                end
            end
            LD_BUSY: begin
                if (load_cnt_r == 4'h0) begin
                    ld_state_nxt = LD_IDLE;
                end else begin
                    load_cnt_nxt = load_cnt_r - 4'h1;
                end
            end
            default: begin
                ld_state_nxt = LD_IDLE;
                load_cnt_nxt = 4'h0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ld_state_r   <= LD_IDLE;
            load_cnt_r   <= 4'h0;
            load_pulse_r <= 1'b0;
            tbl_status_r <= 1'b0;
        end else begin
            ld_state_r   <= ld_state_nxt;
            load_cnt_r   <= load_cnt_nxt;
            load_pulse_r <= load_go;                                   // see RULE_07
            // A table write in the finishing cycle wins over the clear
            if (table_entry_write) begin
                tbl_status_r <= 1'b1;                                  // see RULE_11
            end else if (load_done) begin
                tbl_status_r <= 1'b0;                                  // see RULE_12
            end
        end
    end

    // ------------------------------------------------
    // Outputs
    // ------------------------------------------------
    assign traffic_class_channel_map = tcmap_r;
    assign arb_scheme                = sel_r;
    assign channel_enable            = enable_r;
    assign table_load_pulse          = load_pulse_r;
    assign table_update_pending      = tbl_status_r;

    // ------------------------------------------------
    // Assertions
    // ------------------------------------------------
    sequence s_load_write;
        (load_go && (ld_state_r == LD_IDLE)) ##1 (!table_entry_write) [*8];
    endsequence

    sequence s_load_finish;
        load_done ##1 !tbl_status_r;
    endsequence

    property p_cap_const;
        @(posedge pclk) disable iff (!presetn)
        pready && !pwrite && hit_cap |-> (prdata[7:0] == `CAP_ARB_RST)
            && (prdata[15:14] == 2'b00) && (prdata[31:24] == `CAP_TBL_OFS_RST);
    endproperty
    a_cap_const: assert property (p_cap_const) else $error("capability word wrong"); // see RULE_03

    property p_sel_legal;
        @(posedge pclk) disable iff (!presetn)
        (sel_r == `SCHEME_DEFAULT) || (sel_r == `SCHEME_WRR128);
    endproperty
    a_sel_legal: assert property (p_sel_legal) else $error("illegal scheme stored"); // see RULE_08

    property p_load_reads_zero;
        @(posedge pclk) disable iff (!presetn)
        pready && !pwrite && hit_ctrl |-> !prdata[`CTRL_LOAD_BIT];
    endproperty
    a_load_reads_zero: assert property (p_load_reads_zero) else $error("load bit read one"); // see RULE_07

    property p_status_set;
        @(posedge pclk) disable iff (!presetn)
        table_entry_write |=> tbl_status_r;
    endproperty
    a_status_set: assert property (p_status_set) else $error("table status not set"); // see RULE_11

    property p_status_clear;
        @(posedge pclk) disable iff (!presetn)
        s_load_write |-> s_load_finish;
    endproperty
    a_status_clear: assert property (p_status_clear) else $error("table status stuck"); // see RULE_12

    property p_enable_write;
        @(posedge pclk) disable iff (!presetn)
        wr_go |=> (channel_enable == $past(pwdata[`CTRL_ENABLE_BIT]));
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable not written"); // see RULE_10

    property p_map_write;
        @(posedge pclk) disable iff (!presetn)
        wr_go |=> (traffic_class_channel_map == $past(pwdata[7:0]));
    endproperty
    a_map_write: assert property (p_map_write) else $error("class map not written"); // see RULE_06

    property p_neg_follow;
        @(posedge pclk) disable iff (!presetn)
        pready && !pwrite && hit_stat |-> (prdata[17] == $past(neg_sync_r));
    endproperty
    a_neg_follow: assert property (p_neg_follow) else $error("pending bit wrong"); // see RULE_13

    property p_reserved_zero;
        @(posedge pclk) disable iff (!presetn)
        pready && !pwrite && hit_ctrl |-> (prdata[30:27] == 4'h0) && (prdata[15:8] == 8'h00)
            && (prdata[26:24] == `CHANNEL_ID);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set"); // see RULE_15

    property p_load_pulse;
        @(posedge pclk) disable iff (!presetn)
        load_go |=> table_load_pulse;
    endproperty
    a_load_pulse: assert property (p_load_pulse) else $error("load pulse missing"); // see RULE_07

    property p_slots_load;
        @(posedge pclk) disable iff (!presetn)
        autoload_valid |=> (slots_r == $past(autoload_time_slots));
    endproperty
    a_slots_load: assert property (p_slots_load) else $error("slots not loaded"); // see RULE_04

    property p_map_load;
        @(posedge pclk) disable iff (!presetn)
        autoload_valid && !wr_go |=> (traffic_class_channel_map == $past(autoload_tc_map));
    endproperty
    a_map_load: assert property (p_map_load) else $error("map not loaded"); // see RULE_06

    property p_wrr_select;
        @(posedge pclk) disable iff (!presetn)
        wr_go && (pwdata[`CTRL_SEL_MSB:`CTRL_SEL_LSB] == `SCHEME_WRR128)
            |=> (arb_scheme == `SCHEME_WRR128);
    endproperty
    a_wrr_select: assert property (p_wrr_select) else $error("scheme not stored"); // see RULE_08

    property p_bad_addr;
        @(posedge pclk) disable iff (!presetn)
        pready && !hit_any |-> pslverr && (prdata == 32'h00000000);
    endproperty
    a_bad_addr: assert property (p_bad_addr) else $error("bad address accepted"); // see RULE_15

    property p_ro_ignored;
        @(posedge pclk) disable iff (!presetn)
        acc && pwrite && !hit_ctrl && !autoload_valid |=> $stable(slots_r) && $stable(tcmap_r)
            && $stable(enable_r) && $stable(sel_r);
    endproperty
    a_ro_ignored: assert property (p_ro_ignored) else $error("ro bits written"); // see RULE_15

    property p_ready_pulse;
        @(posedge pclk) disable iff (!presetn)
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held high");

endmodule : vc0_resource_registers

// ==== sim/test_vc0_resource_registers.sv ====
// Self-checking testbench for the channel 0 resource register bank
`timescale 1ns/1ps
`include "vc0_res_regs.svh"

module test_vc0_resource_registers;
    import vc0_res_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    word_t       pwdata;
    logic        pready;
    word_t       prdata;
    logic        pslverr;
    logic        autoload_valid;
    logic [6:0]  autoload_time_slots;
    logic [7:0]  autoload_tc_map;
    logic        table_entry_write;
    logic        negotiation_pending_in;
    logic [7:0]  traffic_class_channel_map;
    scheme_t     arb_scheme;
    logic        channel_enable;
    logic        table_load_pulse;
    logic        table_update_pending;
    word_t       rd;
    logic        err;
    logic        seen;
    scheme_t     exp_s;
    int          failures;
    int          cmp_count;

    vc0_resource_registers vc0_resource_registers_inst (
        .pclk                      (pclk),
        .presetn                   (presetn),
        .psel                      (psel),
        .penable                   (penable),
        .pwrite                    (pwrite),
        .paddr                     (paddr),
        .pwdata                    (pwdata),
        .pready                    (pready),
        .prdata                    (prdata),
        .pslverr                   (pslverr),
        .autoload_valid            (autoload_valid),
        .autoload_time_slots       (autoload_time_slots),
        .autoload_tc_map           (autoload_tc_map),
        .table_entry_write         (table_entry_write),
        .negotiation_pending_in    (negotiation_pending_in),
        .traffic_class_channel_map (traffic_class_channel_map),
        .arb_scheme                (arb_scheme),
        .channel_enable            (channel_enable),
        .table_load_pulse          (table_load_pulse),
        .table_update_pending      (table_update_pending)
    );

    always #5 pclk = ~pclk;

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input word_t got, input word_t exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH at %0t: got %08h expected %08h", $time, got, exp);
        end
    endtask : chk

    // No wait count assumed: polls pready under a bound
    task automatic apb(input logic wr, input logic [11:0] addr, input word_t data);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= data;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            failures++;
        end
    endtask : apb

    task automatic rdchk(input logic [11:0] addr, input word_t exp);
        apb(1'b0, addr, 32'h00000000);
        chk(rd, exp);
    endtask : rdchk

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h00000000; autoload_valid = 1'b0;
        autoload_time_slots = 7'h00; autoload_tc_map = 8'h00;
        table_entry_write = 1'b0; negotiation_pending_in = 1'b0;
        failures = 0; cmp_count = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(`CAP_OFFSET, 32'h047F0009);
        rdchk(`CTRL_OFFSET, 32'h800000FF);
        rdchk(`STAT_OFFSET, 32'h00000000);
        chk({31'h0, err}, 32'h00000000);
        apb(1'b1, `CAP_OFFSET, 32'hFFFFFFFF);
        rdchk(`CAP_OFFSET, 32'h047F0009);
        apb(1'b1, `STAT_OFFSET, 32'hFFFFFFFF);
        rdchk(`STAT_OFFSET, 32'h00000000);
        // Reserved bits 30:27 and 15:8, identifier and bad scheme bits all set at once
        apb(1'b1, `CTRL_OFFSET, 32'h7F0EFF55);
        rdchk(`CTRL_OFFSET, 32'h00000055);
        chk({24'h0, traffic_class_channel_map}, 32'h00000055);
        chk({31'h0, channel_enable}, 32'h00000000);
        for (int s = 0; s < 8; s++) begin
            exp_s = (s == 3) ? 3'h3 : 3'h0;
            apb(1'b1, `CTRL_OFFSET, {1'b1, 11'h000, s[2:0], 17'h000FF});
            rdchk(`CTRL_OFFSET, {1'b1, 11'h000, exp_s, 17'h000FF});
            chk({29'h0, arb_scheme}, {29'h0, exp_s});
        end
        @(posedge pclk);
        table_entry_write <= 1'b1;
        @(posedge pclk);
        table_entry_write <= 1'b0;
        rdchk(`STAT_OFFSET, 32'h00010000);
        chk({31'h0, table_update_pending}, 32'h00000001);
        apb(1'b1, `CTRL_OFFSET, 32'h800100FF);
        seen = 1'b0;
        repeat (2) begin
            #1 seen |= table_load_pulse;
            @(posedge pclk);
        end
        chk({31'h0, seen}, 32'h00000001);
        rdchk(`CTRL_OFFSET, 32'h800000FF);
        repeat (12) @(posedge pclk);
        rdchk(`STAT_OFFSET, 32'h00000000);
        chk({31'h0, table_update_pending}, 32'h00000000);
        // Input is synchronised, so allow the two-flop delay
        negotiation_pending_in <= 1'b1;
        repeat (4) @(posedge pclk);
        rdchk(`STAT_OFFSET, 32'h00020000);
        negotiation_pending_in <= 1'b0;
        repeat (4) @(posedge pclk);
        rdchk(`STAT_OFFSET, 32'h00000000);
        @(posedge pclk);
        autoload_valid      <= 1'b1;
        autoload_time_slots <= 7'h12;
        autoload_tc_map     <= 8'hA5;
        @(posedge pclk);
        autoload_valid      <= 1'b0;
        rdchk(`CAP_OFFSET, 32'h04120009);
        rdchk(`CTRL_OFFSET, 32'h800000A5);
        rdchk(12'h15C, 32'h00000000);
        chk({31'h0, err}, 32'h00000001);
        // Mid-run reset must bring back the autoloaded fields too
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(`CAP_OFFSET, 32'h047F0009);
        rdchk(`CTRL_OFFSET, 32'h800000FF);
        final_report();
    end

    initial begin
        #50000;
        failures++;
        final_report();
    end

endmodule : test_vc0_resource_registers
